// ==== adc_regs_pkg.sv ====
package adc_regs_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [4:0] ADDR_RESULT_ZERO = 5'h00;
    localparam logic [4:0] ADDR_RESULT_THREE = 5'h03;
    localparam logic [4:0] ADDR_SNAPSHOT = 5'h08;
    localparam logic [4:0] ADDR_SPARE = 5'h09;
    localparam logic [4:0] ADDR_SETTINGS = 5'h0C;
    localparam logic [4:0] ADDR_CONFIG_END = 5'h0E;
    localparam logic [4:0] ADDR_CAL_FIRST = 5'h0F;
    localparam logic [4:0] ADDR_CAL_LAST = 5'h16;
    localparam logic [4:0] ADDR_LOCK = 5'h1F;
    localparam int NUM_CH = 4;
    localparam int RES_W = 24;
    localparam int COMP_W = 4;
    localparam int SNAP_W = NUM_CH * COMP_W;
    localparam int FIFO_DEPTH = 8;

    // =====================================================================
    // Field values and reset values
    // =====================================================================
    localparam logic [1:0] RD_ENTIRE = 2'h3;
    localparam logic [1:0] RD_TYPE = 2'h2;
    localparam logic [1:0] RD_GROUP = 2'h1;
    localparam logic [1:0] RD_STATIC = 2'h0;
    localparam logic [1:0] FMT_32_SIGN = 2'h3;
    localparam logic [1:0] FMT_32_ZERO = 2'h2;
    localparam logic [1:0] FMT_24 = 2'h1;
    localparam logic [1:0] FMT_16 = 2'h0;
    localparam logic [3:0] COMP_RESET = 4'h3;
    localparam logic [15:0] SNAP_RESET = 16'h3333;

    typedef struct packed {
        logic [1:0] read_incr;
        logic write_incr;
        logic linked_ready_select;
        logic [1:0] data_width;
    } comm_settings_t;

    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] data;
        logic [1:0] width;
    } read_word_t;

endpackage : adc_regs_pkg

// ==== addr_sequencer.sv ====
`timescale 1ns/1ps
module addr_sequencer
(
    input wire logic [4:0] i_addr,
    input wire logic i_is_write,
    input wire logic [1:0] i_read_incr,
    input wire logic i_write_incr,
    output logic [4:0] o_next
);

    // =====================================================================
    // Next address of a continuous transfer
    // =====================================================================
    always_comb
    begin
        o_next = i_addr;
        if (i_is_write)
        begin
            if (i_write_incr)
            begin
                // Results have no write address; loop 0x08..0x16, then 0x1F, writable
                if (i_addr < adc_regs_pkg::ADDR_SNAPSHOT)
                    o_next = adc_regs_pkg::ADDR_SNAPSHOT;
                else if (i_addr == adc_regs_pkg::ADDR_LOCK)
                    o_next = adc_regs_pkg::ADDR_SNAPSHOT;
                else if (i_addr == adc_regs_pkg::ADDR_CAL_LAST)
                    o_next = adc_regs_pkg::ADDR_LOCK;
                else
                    o_next = i_addr + 5'h01;
            end
        end
        else
        begin
            case (i_read_incr)
                adc_regs_pkg::RD_ENTIRE:
                begin
                    if (i_addr == adc_regs_pkg::ADDR_RESULT_THREE)
                        o_next = adc_regs_pkg::ADDR_SNAPSHOT;
                    else if (i_addr == adc_regs_pkg::ADDR_CAL_LAST)
                        o_next = adc_regs_pkg::ADDR_LOCK;
                    else
                        o_next = i_addr + 5'h01;
                end
                adc_regs_pkg::RD_TYPE:
                begin
                    if (i_addr == adc_regs_pkg::ADDR_RESULT_THREE)
                        o_next = adc_regs_pkg::ADDR_RESULT_ZERO;
                    else if (i_addr == adc_regs_pkg::ADDR_LOCK)
                        o_next = adc_regs_pkg::ADDR_SNAPSHOT;
                    else if (i_addr == adc_regs_pkg::ADDR_CAL_LAST)
                        o_next = adc_regs_pkg::ADDR_LOCK;
                    else
                        o_next = i_addr + 5'h01;
                end
                adc_regs_pkg::RD_GROUP:
                begin
                    if (i_addr <= adc_regs_pkg::ADDR_RESULT_THREE)
                        o_next = {i_addr[4:1], ~i_addr[0]};
                    else if (i_addr == adc_regs_pkg::ADDR_LOCK)
                        o_next = i_addr;
                    else if (i_addr >= adc_regs_pkg::ADDR_CAL_FIRST)
                        // Pairs 0x0F/0x10 .. 0x15/0x16
                        o_next = i_addr[0] ? i_addr + 5'h01
                                           : i_addr - 5'h01;
                    else if (i_addr == 5'h0B)
                        o_next = adc_regs_pkg::ADDR_SNAPSHOT;
                    else if (i_addr == adc_regs_pkg::ADDR_CONFIG_END)
                        o_next = adc_regs_pkg::ADDR_SETTINGS;
                    else
                        o_next = i_addr + 5'h01;
                end
                default:
                    o_next = i_addr;
            endcase
        end
    end

endmodule : addr_sequencer

// ==== word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign o_in_ready = (count_q != DEPTH[AW:0]);
    assign o_out_valid = (count_q != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_q[rd_ptr_q];

    always_ff @(posedge i_clk_sys)
    begin
        if (push)
            mem_q[wr_ptr_q] <= i_in_data;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule : word_fifo

// ==== adc_result_and_modulator_regs.sv ====
`timescale 1ns/1ps
module adc_result_and_modulator_regs #(
    parameter int NUM_CH = adc_regs_pkg::NUM_CH,
    parameter int FIFO_DEPTH = adc_regs_pkg::FIFO_DEPTH
)
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_modulator_clock_tick,
    input wire logic [NUM_CH*24-1:0] i_corrected_code,
    input wire logic [NUM_CH-1:0] i_conv_done,
    input wire logic [NUM_CH*4-1:0] i_comparator_bits,
    input wire adc_regs_pkg::comm_settings_t i_settings,
    input wire logic i_xfer_start,
    input wire logic i_xfer_is_write,
    input wire logic [4:0] i_xfer_addr,
    input wire logic i_xfer_end,
    input wire logic i_word_req,
    input wire logic i_snap_wr,
    input wire logic [15:0] i_snap_wdata,
    input wire logic i_out_ready,
    output logic o_out_valid,
    output adc_regs_pkg::read_word_t o_out_word,
    output logic o_conversion_ready_pin_n,
    output logic o_req_ready,
    output logic [4:0] o_cur_addr,
    output logic o_in_read
);

    // =====================================================================
    // Live results and ready tracking
    // =====================================================================
    logic [23:0] live_q [NUM_CH];
    logic [23:0] frozen_q [NUM_CH];
    logic [NUM_CH-1:0] seen_q;
    logic [NUM_CH-1:0] seen_all;
    logic link_fire;
    logic [NUM_CH-1:0] pending_q;
    logic in_read_q;
    logic is_write_q;
    logic [4:0] addr_q;
    logic [4:0] addr_d;
    logic [15:0] snap_q;
    logic ready_pulse_q;
    logic fifo_in_ready;
    logic fifo_push;
    adc_regs_pkg::read_word_t word_d;
    logic [23:0] sel_reg;
    logic [23:0] rounded;

    assign seen_all = seen_q | i_conv_done;
    assign link_fire = i_settings.linked_ready_select && (&seen_all);

    // Linked mode collects every channel before releasing any value
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            seen_q <= '0;
        else if (!i_settings.linked_ready_select || link_fire)
            seen_q <= '0;
        else
            seen_q <= seen_all;
    end

    // Staging holds the corrected code until it may be published
    logic [23:0] stage_q [NUM_CH];

    generate
        for (genvar c = 0; c < NUM_CH; c++)
        begin : g_ch
            logic publish;
            assign publish = i_settings.linked_ready_select ? link_fire
                                                             : i_conv_done[c];
            always_ff @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                    stage_q[c] <= '0;
                else if (i_conv_done[c])
                    stage_q[c] <= i_corrected_code[c*24 +: 24];
            end
            always_ff @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                    live_q[c] <= '0;
                else if (publish)
                    live_q[c] <= i_conv_done[c]
                                 ? i_corrected_code[c*24 +: 24]
                                 : stage_q[c];
            end
            // Frozen copy seen by the host; whole words only
            always_ff @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                    frozen_q[c] <= '0;
                else if (!in_read_q || (i_xfer_start && !i_xfer_is_write))
                    frozen_q[c] <= live_q[c];
                else if (pending_q[c] && i_word_req && fifo_in_ready
                         && addr_q == 5'(c))
                    frozen_q[c] <= live_q[c];
            end
            always_ff @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                    pending_q[c] <= 1'b0;
                else if (in_read_q && publish)
                    pending_q[c] <= 1'b1;
                else if (!in_read_q || (i_word_req && fifo_in_ready
                         && addr_q == 5'(c)))
                    pending_q[c] <= 1'b0;
            end
        end
    endgenerate

    // =====================================================================
    // Ready pin, active low pulse
    // =====================================================================
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            ready_pulse_q <= 1'b0;
        else
            ready_pulse_q <= i_settings.linked_ready_select ? link_fire
                                                            : |i_conv_done;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_conversion_ready_pin_n <= 1'b1;
        else
            o_conversion_ready_pin_n <= ~ready_pulse_q;
    end

    // =====================================================================
    // Modulator snapshot
    // =====================================================================
    // Host writes land unless a tick comes that cycle; the next tick overwrites them
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            snap_q <= adc_regs_pkg::SNAP_RESET;
        else if (i_modulator_clock_tick)
            snap_q <= i_comparator_bits[15:0];
        else if (i_snap_wr)
            snap_q <= i_snap_wdata;
    end

    // =====================================================================
    // Transfer address tracking
    // =====================================================================
    addr_sequencer u_seq
    (
        .i_addr(addr_q),
        .i_is_write(is_write_q),
        .i_read_incr(i_settings.read_incr),
        .i_write_incr(i_settings.write_incr),
        .o_next(addr_d)
    );

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            in_read_q <= 1'b0;
            is_write_q <= 1'b0;
            addr_q <= '0;
        end
        else if (i_xfer_start)
        begin
            in_read_q <= !i_xfer_is_write;
            is_write_q <= i_xfer_is_write;
            addr_q <= i_xfer_addr;
        end
        else if (i_xfer_end)
            in_read_q <= 1'b0;
        else if (i_word_req && (is_write_q || fifo_in_ready))
            addr_q <= addr_d;
    end

    // =====================================================================
    // Word formatting
    // =====================================================================
    always_comb
    begin
        sel_reg = '0;
        if (addr_q <= adc_regs_pkg::ADDR_RESULT_THREE)
            sel_reg = frozen_q[addr_q[1:0]];
        else if (addr_q == adc_regs_pkg::ADDR_SNAPSHOT)
            sel_reg = {8'h00, snap_q};
    end

    // Rounding saturates so positive full scale cannot wrap negative
    assign rounded = (sel_reg[23:8] == 16'h7FFF) ? sel_reg
                                                  : sel_reg + 24'h000080;

    always_comb
    begin
        word_d.addr = addr_q;
        word_d.width = i_settings.data_width;
        word_d.data = {8'h00, sel_reg};
        if (addr_q <= adc_regs_pkg::ADDR_RESULT_THREE)
        begin
            case (i_settings.data_width)
                adc_regs_pkg::FMT_32_SIGN:
                    word_d.data = {{8{sel_reg[23]}}, sel_reg};
                adc_regs_pkg::FMT_32_ZERO:
                    word_d.data = {sel_reg, 8'h00};
                adc_regs_pkg::FMT_16:
                    word_d.data = {16'h0000, rounded[23:8]};
                default:
                    word_d.data = {8'h00, sel_reg};
            endcase
        end
        else
            word_d.width = adc_regs_pkg::FMT_24;
    end

    assign fifo_push = i_word_req && in_read_q;

    word_fifo #(
        .WIDTH($bits(adc_regs_pkg::read_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo
    (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(word_d),
        .o_out_valid(o_out_valid),
        .i_out_ready(i_out_ready),
        .o_out_data(o_out_word)
    );

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_req_ready <= 1'b0;
        else
            o_req_ready <= fifo_in_ready;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_cur_addr <= '0;
        else
            o_cur_addr <= addr_d;
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_in_read <= 1'b0;
        else
            o_in_read <= in_read_q;
    end

endmodule : adc_result_and_modulator_regs

// ==== adc_regs_sva.sv ====
`timescale 1ns/1ps
module adc_regs_sva #(
    parameter int NUM_CH = 4
)
(
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [NUM_CH-1:0] i_conv_done,
    input wire adc_regs_pkg::comm_settings_t i_settings,
    input wire logic i_word_req,
    input wire logic i_out_ready,
    input wire logic o_out_valid,
    input wire adc_regs_pkg::read_word_t o_out_word,
    input wire logic o_conversion_ready_pin_n,
    input wire logic [4:0] o_cur_addr,
    input wire logic o_in_read
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    // ==========
    // Helpers
    // ==========
    wire is_res = o_out_valid && (o_out_word.addr <= 5'h03);
    wire is_wr_word = i_word_req && !o_in_read;
    sequence s_push;
        o_in_read && i_word_req;
    endsequence
    sequence s_pop_stall;
        o_out_valid && !i_out_ready;
    endsequence

    AST_READY_CAUSE: assert property (!o_conversion_ready_pin_n |-> $past(|i_conv_done, 2)) else $error("ready pin low without a conversion");
    AST_READY_EACH: assert property ((|i_conv_done && !i_settings.linked_ready_select) |-> ##2 !o_conversion_ready_pin_n) else $error("missing unlinked ready pulse");
    AST_READY_SHORT: assert property ((!o_conversion_ready_pin_n && !$past(|i_conv_done)) |=> o_conversion_ready_pin_n) else $error("ready pulse too long");
    AST_SNAP_UPPER: assert property ((o_out_valid && o_out_word.addr == adc_regs_pkg::ADDR_SNAPSHOT) |-> o_out_word.data[31:16] == 16'h0000) else $error("snapshot upper bits set");
    AST_FMT_24: assert property ((is_res && o_out_word.width == adc_regs_pkg::FMT_24) |-> o_out_word.data[31:24] == 8'h00) else $error("24-bit word padded wrongly");
    AST_FMT_ZERO: assert property ((is_res && o_out_word.width == adc_regs_pkg::FMT_32_ZERO) |-> o_out_word.data[7:0] == 8'h00) else $error("zero pad missing");
    AST_FMT_SIGN: assert property ((is_res && o_out_word.width == adc_regs_pkg::FMT_32_SIGN) |-> o_out_word.data[31:24] == {8{o_out_word.data[23]}}) else $error("sign extension wrong");
    AST_FMT_16: assert property ((is_res && o_out_word.width == adc_regs_pkg::FMT_16) |-> o_out_word.data[31:16] == 16'h0000) else $error("16-bit word wrong");
    AST_HOLD: assert property (s_pop_stall |=> o_out_valid && $stable(o_out_word)) else $error("head word changed while stalled");
    AST_PUSH: assert property (s_push |-> ##[1:2] o_out_valid) else $error("read word not delivered");
    AST_STATIC_RD: assert property ((s_push and (i_settings.read_incr == adc_regs_pkg::RD_STATIC)) |=> $stable(o_cur_addr)) else $error("static read moved");
    // Current address shows one cycle late, so look one word behind
    AST_STATIC_WR: assert property ((is_wr_word && $past(is_wr_word) && !i_settings.write_incr) |=> $stable(o_cur_addr)) else $error("static write moved");
    AST_WR_WRAP: assert property (($past(is_wr_word) && !o_in_read && i_settings.write_incr && o_cur_addr == adc_regs_pkg::ADDR_LOCK) |=> o_cur_addr == adc_regs_pkg::ADDR_SNAPSHOT) else $error("write wrap wrong");
endmodule : adc_regs_sva

bind adc_result_and_modulator_regs adc_regs_sva #(.NUM_CH(NUM_CH)) u_sva (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_conv_done(i_conv_done), .i_settings(i_settings), .i_word_req(i_word_req), .i_out_ready(i_out_ready), .o_out_valid(o_out_valid), .o_out_word(o_out_word), .o_conversion_ready_pin_n(o_conversion_ready_pin_n), .o_cur_addr(o_cur_addr), .o_in_read(o_in_read));

// ==== host_xfer_model.sv ====
`timescale 1ns/1ps
module host_xfer_model
(
    input wire logic i_clk_sys,
    input wire logic i_go,
    input wire logic i_write,
    input wire logic i_slow,
    input wire logic [4:0] i_addr,
    input wire logic [4:0] i_words,
    input wire logic i_req_ready,
    output logic o_xfer_start,
    output logic o_xfer_is_write,
    output logic [4:0] o_xfer_addr,
    output logic o_xfer_end,
    output logic o_word_req,
    output logic o_snap_wr,
    output logic [15:0] o_snap_wdata,
    output logic o_busy
);
    int n;
    // Snapshot is never written by the host
    assign o_snap_wr = 1'b0;
    assign o_snap_wdata = 16'h0000;
    initial
    begin
        o_xfer_start = 1'b0;
        o_xfer_is_write = 1'b0;
        o_xfer_addr = 5'h00;
        o_xfer_end = 1'b0;
        o_word_req = 1'b0;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_clk_sys);
            if (i_go)
            begin
                o_busy <= 1'b1;
                o_xfer_start <= 1'b1;
                o_xfer_is_write <= i_write;
                o_xfer_addr <= i_addr;
                @(posedge i_clk_sys);
                o_xfer_start <= 1'b0;
                n = 0;
                while (n < i_words)
                begin
                    // Ready lags a cycle, so slow mode waits it out
                    o_word_req <= i_req_ready || o_xfer_is_write;
                    @(posedge i_clk_sys);
                    if (o_word_req)
                        n++;
                    if (i_slow && o_word_req)
                    begin
                        o_word_req <= 1'b0;
                        repeat (2) @(posedge i_clk_sys);
                    end
                end
                o_word_req <= 1'b0;
                o_xfer_end <= 1'b1;
                @(posedge i_clk_sys);
                o_xfer_end <= 1'b0;
                o_busy <= 1'b0;
            end
        end
    end
endmodule : host_xfer_model

// ==== adc_result_and_modulator_regs_tb.sv ====
`timescale 1ns/1ps
module adc_result_and_modulator_regs_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tick = 1'b0;
    logic [95:0] code = '0;
    logic [3:0] done = 4'h0;
    logic [15:0] comp = 16'h0000;
    adc_regs_pkg::comm_settings_t st = 6'h09;
    logic ordy = 1'b0;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic slow = 1'b0;
    logic [4:0] a0 = 5'h00;
    logic [4:0] nw = 5'h01;
    logic start, is_wr, xend, wreq, swr, busy, ovalid, pin_n, rq_rdy, in_rd;
    logic [4:0] xaddr;
    logic [4:0] cur;
    logic [15:0] swd;
    adc_regs_pkg::read_word_t ow;
    logic [11:0] tbl [12];
    int fails = 0;
    int tests_run = 0;
    int lows = 0;

    adc_result_and_modulator_regs #(.NUM_CH(4), .FIFO_DEPTH(8)) dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_modulator_clock_tick(tick),
        .i_corrected_code(code), .i_conv_done(done),
        .i_comparator_bits(comp), .i_settings(st), .i_xfer_start(start),
        .i_xfer_is_write(is_wr), .i_xfer_addr(xaddr), .i_xfer_end(xend),
        .i_word_req(wreq), .i_snap_wr(swr), .i_snap_wdata(swd),
        .i_out_ready(ordy), .o_out_valid(ovalid), .o_out_word(ow),
        .o_conversion_ready_pin_n(pin_n), .o_req_ready(rq_rdy),
        .o_cur_addr(cur), .o_in_read(in_rd));

    host_xfer_model host (
        .i_clk_sys(clk), .i_go(go), .i_write(wr), .i_slow(slow),
        .i_addr(a0), .i_words(nw), .i_req_ready(rq_rdy),
        .o_xfer_start(start), .o_xfer_is_write(is_wr), .o_xfer_addr(xaddr),
        .o_xfer_end(xend), .o_word_req(wreq), .o_snap_wr(swr),
        .o_snap_wdata(swd), .o_busy(busy));

    always #20 clk = ~clk;
    always @(posedge clk)
        if (pin_n === 1'b0)
            lows++;

    // ==========
    // Tasks
    // ==========
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [4:0] a,
                        input logic [4:0] n, input logic wt);
        int k;
        k = 0;
        @(posedge clk);
        wr <= w;
        a0 <= a;
        nw <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (wt && busy !== 1'b0 && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 300)
            fails++;
    endtask : xfer

    task automatic pop(input logic [4:0] ea, input logic [31:0] ed,
                       input logic cd);
        int k;
        k = 0;
        @(negedge clk);
        while (ovalid !== 1'b1 && k < 50)
        begin
            @(negedge clk);
            k++;
        end
        chk({27'h0, ow.addr}, {27'h0, ea});
        if (cd)
            chk(ow.data, ed);
        @(posedge clk);
        ordy <= 1'b1;
        @(posedge clk);
        ordy <= 1'b0;
    endtask : pop

    task automatic pulse(input logic [3:0] m);
        @(posedge clk);
        done <= m;
        @(posedge clk);
        done <= 4'h0;
        repeat (3) @(posedge clk);
    endtask : pulse

    function automatic logic [31:0] fmt(input logic [23:0] c,
                                        input logic [1:0] w);
        logic [15:0] r;
        r = c[23:8] + {15'h0, c[7]};
        // Rounding must not flip a positive full scale negative
        if (!c[23] && r == 16'h8000)
            r = 16'h7FFF;
        case (w)
            adc_regs_pkg::FMT_32_SIGN: fmt = {{8{c[23]}}, c};
            adc_regs_pkg::FMT_32_ZERO: fmt = {c, 8'h00};
            adc_regs_pkg::FMT_24: fmt = {8'h00, c};
            default: fmt = {16'h0000, r};
        endcase
    endfunction : fmt

    initial
    begin
        #(40 * 30000);
        fails++;
        results();
    end

    // ==========
    // Tests
    // ==========
    initial
    begin
        tbl = '{{2'h3, 5'h1F, 5'h00}, {2'h3, 5'h03, 5'h08},
                {2'h3, 5'h16, 5'h1F}, {2'h2, 5'h03, 5'h00},
                {2'h2, 5'h16, 5'h1F}, {2'h2, 5'h1F, 5'h08},
                {2'h1, 5'h01, 5'h00}, {2'h1, 5'h0B, 5'h08},
                {2'h1, 5'h0E, 5'h0C}, {2'h1, 5'h10, 5'h0F},
                {2'h1, 5'h1F, 5'h1F}, {2'h0, 5'h02, 5'h02}};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        xfer(1'b0, 5'h08, 5'h01, 1'b1);
        pop(5'h08, 32'h00003333, 1'b1);
        xfer(1'b0, 5'h00, 5'h01, 1'b1);
        pop(5'h00, 32'h00000000, 1'b1);
        @(posedge clk);
        tick <= 1'b1;
        comp <= 16'h9A5C;
        @(posedge clk);
        tick <= 1'b0;
        xfer(1'b0, 5'h08, 5'h01, 1'b1);
        pop(5'h08, 32'h00009A5C, 1'b1);
        $display("test reset and snapshot done");
        code <= {24'h00ABCD, 24'h123456, 24'h800001, 24'h7FFF80};
        pulse(4'hF);
        st.read_incr <= adc_regs_pkg::RD_TYPE;
        for (int f = 0; f < 4; f++)
        begin
            st.data_width <= 2'(f);
            xfer(1'b0, 5'h00, 5'h04, 1'b1);
            for (int c = 0; c < 4; c++)
                pop(5'(c), fmt(code[c*24+:24], 2'(f)), 1'b1);
        end
        $display("test formats done");
        st.data_width <= adc_regs_pkg::FMT_24;
        st.read_incr <= adc_regs_pkg::RD_STATIC;
        st.linked_ready_select <= 1'b1;
        code <= {4{24'h5A5A5A}};
        lows = 0;
        pulse(4'h1);
        pulse(4'h2);
        pulse(4'h4);
        xfer(1'b0, 5'h00, 5'h01, 1'b1);
        pop(5'h00, 32'h007FFF80, 1'b1);
        pulse(4'h8);
        xfer(1'b0, 5'h03, 5'h01, 1'b1);
        pop(5'h03, 32'h005A5A5A, 1'b1);
        chk(32'(lows), 32'h00000001);
        st.linked_ready_select <= 1'b0;
        lows = 0;
        for (int c = 0; c < 4; c++)
            pulse(4'(1 << c));
        chk(32'(lows), 32'h00000004);
        $display("test ready link done");
        for (int i = 0; i < 12; i++)
        begin
            st.read_incr <= tbl[i][11:10];
            xfer(1'b0, tbl[i][9:5], 5'h02, 1'b1);
            pop(tbl[i][9:5], 32'h0, 1'b0);
            pop(tbl[i][4:0], 32'h0, 1'b0);
        end
        st.write_incr <= 1'b1;
        xfer(1'b1, 5'h16, 5'h03, 1'b1);
        @(negedge clk);
        chk({27'h0, cur}, 32'h0000000A);
        @(posedge clk);
        st.write_incr <= 1'b0;
        xfer(1'b1, 5'h0C, 5'h02, 1'b1);
        @(negedge clk);
        chk({31'h0, ovalid}, 32'h0);
        chk({27'h0, cur}, 32'h0000000C);
        $display("test address loops done");
        // Conversions land mid-read: this read keeps the old words
        st.read_incr <= adc_regs_pkg::RD_TYPE;
        slow <= 1'b1;
        code <= {4{24'h0F0F0F}};
        xfer(1'b0, 5'h00, 5'h04, 1'b0);
        pulse(4'hF);
        for (int c = 0; c < 4; c++)
            pop(5'(c), 32'h005A5A5A, 1'b1);
        repeat (4) @(posedge clk);
        xfer(1'b0, 5'h00, 5'h04, 1'b1);
        for (int c = 0; c < 4; c++)
            pop(5'(c), 32'h000F0F0F, 1'b1);
        st.read_incr <= adc_regs_pkg::RD_STATIC;
        xfer(1'b0, 5'h08, 5'h09, 1'b0);
        repeat (40) @(negedge clk);
        chk({31'h0, rq_rdy}, 32'h0);
        chk({31'h0, ovalid}, 32'h1);
        repeat (9) pop(5'h08, 32'h00009A5C, 1'b1);
        repeat (4) @(negedge clk);
        chk({31'h0, ovalid}, 32'h0);
        $display("test buffer done");
        results();
    end
endmodule : adc_result_and_modulator_regs_tb
